/* File: rwc_consts.svh */
// constants for the redundant word character display block
`ifndef RWC_CONSTS_SVH
`define RWC_CONSTS_SVH
`define RWC_WORD_W 12
`define RWC_BITCNT_W 4
`define RWC_LAST_BIT 4'hB
`define RWC_PAGES 20
`define RWC_PAGE_W 5
`define RWC_BODY_LINES 24
`define RWC_BODY_CHARS 40
`define RWC_EDGE_CHARS 32
`define RWC_LINE_W 5
`define RWC_COL_W 6
`define RWC_HDR_LINE 5'h00
`define RWC_FTR_LINE 5'h19
`define RWC_TOP_LAST 5'h0C
`define RWC_PAGE_WORDS 1024
`define RWC_FTR_BASE 992
`define RWC_ADDR_W 15
`define RWC_CHAR_W 6
`define RWC_BLINK_BIT 6
`define RWC_OP_LSB 10
`define RWC_CLK_NS 8
`define RWC_SEC_NS 1000000000
`define RWC_HALF_SEC_CYC (`RWC_SEC_NS / `RWC_CLK_NS / 2)
`define RWC_MIN_SCANS 30
`define RWC_FRAME_MAX (`RWC_SEC_NS / `RWC_CLK_NS / `RWC_MIN_SCANS)
`endif

/* File: rwc_pkg.sv */
// types for the redundant word character display block
package rwc_pkg;
  typedef enum logic {RWC_FIRST = 1'b0, RWC_SECOND = 1'b1} rwc_copy_e;
  typedef enum logic [1:0] {
    RWC_OP_PAGE = 2'h0,
    RWC_OP_LINE = 2'h1,
    RWC_OP_COL = 2'h2,
    RWC_OP_CHAR = 2'h3
  } rwc_op_e;
  typedef logic [11:0] rwc_word_t;
endpackage : rwc_pkg

/* File: rwc_display.sv */
// redundancy check receiver and character symbol generator
`timescale 1ns/1ps
`include "rwc_consts.svh"
module rwc_display #(
  parameter int CHANNELS = 4,
  parameter int HALF_SEC_CYC = `RWC_HALF_SEC_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial link pins
  input wire logic link_bclk,
  input wire logic link_data,
  input wire logic link_frame,
  // accepted word
  output rwc_pkg::rwc_word_t word_data,
  output logic word_vld,
  output logic word_err,
  // display channel selection pins
  input wire logic [CHANNELS*`RWC_PAGE_W-1:0] chan_page,
  input wire logic [CHANNELS-1:0] chan_bottom,
  // scan output
  output logic scan_vld,
  output logic [`RWC_CHAR_W-1:0] scan_char,
  output logic [`RWC_PAGE_W-1:0] scan_page,
  output logic [`RWC_LINE_W-1:0] scan_line,
  output logic [`RWC_COL_W-1:0] scan_col,
  output logic scan_frame,
  output logic [CHANNELS-1:0] chan_hit,
  // update timing
  output logic upd_tick,
  output logic upd_stale
);
  import rwc_pkg::*;

  function automatic logic [`RWC_COL_W-1:0] line_width(
    input logic [`RWC_LINE_W-1:0] l);
    line_width = (l == `RWC_HDR_LINE || l == `RWC_FTR_LINE) ?
      `RWC_COL_W'(`RWC_EDGE_CHARS) : `RWC_COL_W'(`RWC_BODY_CHARS);
  endfunction : line_width

  function automatic logic [`RWC_ADDR_W-1:0] char_addr(
    input logic [`RWC_PAGE_W-1:0] p, input logic [`RWC_LINE_W-1:0] l,
    input logic [`RWC_COL_W-1:0] c);
    logic [`RWC_ADDR_W-1:0] off;
    off = `RWC_ADDR_W'(c);
    if (l == `RWC_FTR_LINE)
      off = `RWC_ADDR_W'(`RWC_FTR_BASE) + `RWC_ADDR_W'(c);
    else if (l != `RWC_HDR_LINE)
      off = `RWC_ADDR_W'(`RWC_EDGE_CHARS) + `RWC_ADDR_W'(c) +
        `RWC_ADDR_W'((l - 5'h01) * `RWC_BODY_CHARS);
    char_addr = `RWC_ADDR_W'(p * `RWC_PAGE_WORDS) + off;
  endfunction : char_addr

  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_s1_r, pin_s2_r;
  logic bclk_d_r;
  logic [CHANNELS*`RWC_PAGE_W-1:0] cpage_s1_r, cpage_s2_r;
  logic [CHANNELS-1:0] cbot_s1_r, cbot_s2_r;
  always_ff @(posedge core_clk) begin
    pin_s1_r <= {link_bclk, link_data, link_frame};
    pin_s2_r <= pin_s1_r;
    bclk_d_r <= pin_s2_r[2];
    cpage_s1_r <= chan_page;
    cpage_s2_r <= cpage_s1_r;
    cbot_s1_r <= chan_bottom;
    cbot_s2_r <= cbot_s1_r;
  end

  // ==========================================================
  // deserialiser, msb first
  logic [`RWC_WORD_W-1:0] shift_r;
  logic [`RWC_BITCNT_W-1:0] bitcnt_r;
  wire bit_rise = pin_s2_r[2] & ~bclk_d_r;
  wire frame_on = pin_s2_r[0];
  wire [`RWC_WORD_W-1:0] new_word = {shift_r[`RWC_WORD_W-2:0], pin_s2_r[1]};
  wire word_done = bit_rise & frame_on & (bitcnt_r == `RWC_LAST_BIT);
  always_ff @(posedge core_clk) begin
    if (sys_rst || !frame_on || word_done) begin
      bitcnt_r <= '0;
    end else if (bit_rise) begin
      bitcnt_r <= bitcnt_r + 4'h1;
    end
    if (bit_rise && frame_on) begin
      shift_r <= new_word;
    end
  end

  // ==========================================================
  // redundancy check
  rwc_copy_e copy_r;
  rwc_word_t hold_r;
  wire copies_match = (new_word == hold_r);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      copy_r <= RWC_FIRST;
      word_vld <= 1'b0;
      word_err <= 1'b0;
      word_data <= '0;
    end else begin
      word_vld <= word_done && copy_r == RWC_SECOND && copies_match;
      word_err <= word_done && copy_r == RWC_SECOND && !copies_match;
      if (word_done) begin
        unique case (copy_r)
          RWC_FIRST: begin
            hold_r <= new_word;
            copy_r <= RWC_SECOND;
          end
          RWC_SECOND: begin
            copy_r <= RWC_FIRST;
            if (copies_match) begin
              word_data <= new_word;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // symbol generator: decode and write
  logic [`RWC_CHAR_W:0] mem [0:`RWC_PAGES*`RWC_PAGE_WORDS-1];
  logic [`RWC_PAGE_W-1:0] wpage_r;
  logic [`RWC_LINE_W-1:0] wline_r;
  logic [`RWC_COL_W-1:0] wcol_r;
  wire rwc_op_e op = rwc_op_e'(word_data[`RWC_WORD_W-1:`RWC_OP_LSB]);
  wire [`RWC_PAGE_W-1:0] arg_page = word_data[`RWC_PAGE_W-1:0];
  wire [`RWC_LINE_W-1:0] arg_line = word_data[`RWC_LINE_W-1:0];
  wire [`RWC_COL_W-1:0] arg_col = word_data[`RWC_COL_W-1:0];
  wire char_wr = word_vld && op == RWC_OP_CHAR &&
    wcol_r < line_width(wline_r);
  wire [`RWC_ADDR_W-1:0] wr_addr = char_addr(wpage_r, wline_r, wcol_r);
  // bit 6 is blink, bits 5..0 the character code
  wire [`RWC_CHAR_W:0] wr_entry =
    {word_data[`RWC_BLINK_BIT], word_data[`RWC_CHAR_W-1:0]};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wpage_r <= '0;
      wline_r <= '0;
      wcol_r <= '0;
    end else if (word_vld) begin
      unique case (op)
        RWC_OP_PAGE: if (arg_page < `RWC_PAGE_W'(`RWC_PAGES)) begin
          wpage_r <= arg_page;
          wline_r <= '0;
          wcol_r <= '0;
        end
        RWC_OP_LINE: if (arg_line <= `RWC_FTR_LINE) begin
          wline_r <= arg_line;
          wcol_r <= '0;
        end
        RWC_OP_COL: wcol_r <= arg_col;
        RWC_OP_CHAR: if (char_wr) wcol_r <= wcol_r + 6'h01;
      endcase
    end
    if (char_wr) begin
      mem[wr_addr] <= wr_entry;
    end
  end

  // ==========================================================
  // half-second timer: blink phase and one-second update tick
  logic [31:0] tmr_r;
  logic blink_ph_r, wrote_r;
  wire half_end = (tmr_r == 32'(HALF_SEC_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tmr_r <= '0;
      blink_ph_r <= 1'b0;
      upd_tick <= 1'b0;
      upd_stale <= 1'b0;
      wrote_r <= 1'b0;
    end else begin
      tmr_r <= half_end ? '0 : tmr_r + 32'h1;
      if (half_end) blink_ph_r <= ~blink_ph_r;
      upd_tick <= half_end & blink_ph_r;
      if (half_end & blink_ph_r) begin
        upd_stale <= ~(wrote_r | char_wr);
        wrote_r <= 1'b0;
      end else if (char_wr) begin
        wrote_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // memory scan for refresh
  logic [`RWC_PAGE_W-1:0] spage_r;
  logic [`RWC_LINE_W-1:0] sline_r;
  logic [`RWC_COL_W-1:0] scol_r;
  wire col_last = (scol_r == line_width(sline_r) - 6'h01);
  wire line_last = (sline_r == `RWC_FTR_LINE);
  wire page_last = (spage_r == `RWC_PAGE_W'(`RWC_PAGES - 1));
  wire [`RWC_CHAR_W:0] rd_entry = mem[char_addr(spage_r, sline_r, scol_r)];
  wire top_half = (sline_r <= `RWC_TOP_LAST);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spage_r <= '0;
      sline_r <= '0;
      scol_r <= '0;
      scan_vld <= 1'b0;
      scan_frame <= 1'b0;
    end else begin
      scan_vld <= 1'b1;
      scan_frame <= col_last & line_last & page_last;
      scol_r <= col_last ? '0 : scol_r + 6'h01;
      if (col_last) sline_r <= line_last ? '0 : sline_r + 5'h01;
      if (col_last && line_last) begin
        spage_r <= page_last ? '0 : spage_r + 5'h01;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    scan_char <= (rd_entry[`RWC_BLINK_BIT] & blink_ph_r) ?
      '0 : rd_entry[`RWC_CHAR_W-1:0];
    scan_page <= spage_r;
    scan_line <= sline_r;
    scan_col <= scol_r;
  end
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    always_ff @(posedge core_clk) begin
      chan_hit[i] <= !sys_rst &&
        cpage_s2_r[i*`RWC_PAGE_W +: `RWC_PAGE_W] == spage_r &&
        cbot_s2_r[i] == !top_half;
    end
  end

  // ==========================================================
  // assertions
  logic [31:0] since_frame_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || scan_frame) since_frame_r <= '0;
    else since_frame_r <= since_frame_r + 32'h1;
  end

  property p_bit_count;
    @(posedge core_clk) disable iff (sys_rst) bitcnt_r <= `RWC_LAST_BIT;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit counter beyond word length");
  property p_hold_first;
    @(posedge core_clk) disable iff (sys_rst)
      word_done && copy_r == RWC_FIRST |=>
        copy_r == RWC_SECOND && hold_r == $past(new_word) && !word_vld;
  endproperty
  a_hold_first: assert property (p_hold_first)
    else $error("first copy not held");
  property p_match_fwd;
    @(posedge core_clk) disable iff (sys_rst)
      word_done && copy_r == RWC_SECOND && copies_match |=>
        word_vld && word_data == $past(hold_r) && copy_r == RWC_FIRST;
  endproperty
  a_match_fwd: assert property (p_match_fwd)
    else $error("matching word not forwarded");
  property p_mismatch_drop;
    @(posedge core_clk) disable iff (sys_rst)
      word_done && copy_r == RWC_SECOND && !copies_match |=>
        !word_vld && word_err && copy_r == RWC_FIRST && $stable(word_data);
  endproperty
  a_mismatch_drop: assert property (p_mismatch_drop)
    else $error("mismatched word not dropped");
  property p_char_store;
    @(posedge core_clk) disable iff (sys_rst)
      char_wr |=> mem[$past(wr_addr)] == $past(wr_entry) &&
        wcol_r == $past(wcol_r) + 6'h01;
  endproperty
  a_char_store: assert property (p_char_store)
    else $error("character not written");
  property p_page_range;
    @(posedge core_clk) disable iff (sys_rst)
      wpage_r < `RWC_PAGE_W'(`RWC_PAGES) && spage_r < `RWC_PAGE_W'(`RWC_PAGES);
  endproperty
  a_page_range: assert property (p_page_range)
    else $error("page index out of range");
  property p_line_width;
    @(posedge core_clk) disable iff (sys_rst)
      scol_r < line_width(sline_r) && sline_r <= `RWC_FTR_LINE;
  endproperty
  a_line_width: assert property (p_line_width)
    else $error("scan beyond line length");
  property p_scan_rate;
    @(posedge core_clk) disable iff (sys_rst)
      since_frame_r <= 32'(`RWC_FRAME_MAX);
  endproperty
  a_scan_rate: assert property (p_scan_rate)
    else $error("memory scan too slow");
  property p_blink;
    @(posedge core_clk) disable iff (sys_rst)
      rd_entry[`RWC_BLINK_BIT] && blink_ph_r |=> scan_char == '0;
  endproperty
  a_blink: assert property (p_blink)
    else $error("blinking character shown in off phase");
  property p_tick;
    @(posedge core_clk) disable iff (sys_rst)
      upd_tick |=> !upd_tick ##0 $past(blink_ph_r, 2);
  endproperty
  a_tick: assert property (p_tick)
    else $error("update tick out of phase");

  c_accept: cover property (@(posedge core_clk) disable iff (sys_rst)
    word_vld && op == RWC_OP_CHAR);
  c_reject: cover property (@(posedge core_clk) disable iff (sys_rst)
    word_err ##[1:200] word_vld);
  c_frame: cover property (@(posedge core_clk) disable iff (sys_rst)
    scan_frame);
  c_hit: cover property (@(posedge core_clk) disable iff (sys_rst)
    chan_hit[0]);
endmodule : rwc_display

/* File: rwc_link_src.sv */
// serial link sender standing in for the remote display computer
`timescale 1ns/1ps
// ==========================================================
// link sender
module rwc_link_src (
  // clock
  input wire logic core_clk,
  // link pins
  output logic link_bclk,
  output logic link_data,
  output logic link_frame
);
  import rwc_pkg::*;
  localparam int HALF_CYC = 4;
  initial begin
    link_bclk = 1'b0;
    link_data = 1'b0;
    link_frame = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // one copy, msb first; bit clock stands still outside the frame
  task automatic send_copy(input rwc_word_t w);
    int i;
    step(1);
    link_frame = 1'b1;
    for (i = 11; i >= 0; i--) begin
      link_data = w[i];
      step(HALF_CYC);
      link_bclk = 1'b1;
      step(HALF_CYC);
      link_bclk = 1'b0;
    end
    link_frame = 1'b0;
    // released line shows no stale bit
    link_data = ~link_data;
  endtask : send_copy
  // every word twice in a row; bad flips one bit of the second copy
  task automatic send_pair(input rwc_word_t w, input logic bad);
    send_copy(w);
    send_copy(bad ? w ^ 12'h001 : w);
  endtask : send_pair
endmodule : rwc_link_src

/* File: tb_redundant_word_char_display.sv */
// self-checking bench for the redundant word character display
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb_redundant_word_char_display;
  import rwc_pkg::*;
  typedef struct {rwc_word_t w; logic bad; logic vld; logic err;} rwc_row_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic link_bclk, link_data, link_frame;
  rwc_word_t word_data;
  logic word_vld, word_err, scan_vld, scan_frame, upd_tick, upd_stale;
  logic [19:0] chan_page = {5'h13, 5'h07, 5'h03, 5'h00};
  logic [3:0] chan_bottom = 4'h8;
  logic [5:0] scan_char, scan_col;
  logic [4:0] scan_page, scan_line;
  logic [3:0] chan_hit;
  int mismatches = 0;
  int compares = 0;
  localparam int HALF = 16;
  int run_cyc = 0;
  // page 20 is refused, so the last char lands on page 19 line 13 col 0
  rwc_row_s rows[11] = '{'{12'h000, 1'b0, 1'b1, 1'b0},
    '{12'h400, 1'b0, 1'b1, 1'b0}, '{12'h805, 1'b0, 1'b1, 1'b0},
    '{12'hC2A, 1'b0, 1'b1, 1'b0}, '{12'hC55, 1'b0, 1'b1, 1'b0},
    '{12'h123, 1'b1, 1'b0, 1'b1}, '{12'hA5A, 1'b0, 1'b1, 1'b0},
    '{12'h013, 1'b0, 1'b1, 1'b0}, '{12'h014, 1'b0, 1'b1, 1'b0},
    '{12'h40D, 1'b0, 1'b1, 1'b0}, '{12'hC01, 1'b0, 1'b1, 1'b0}};
  always #4 core_clk = ~core_clk;
  // clock edges since reset release, for the expected blink phase
  always @(posedge core_clk) run_cyc <= sys_rst ? 0 : run_cyc + 1;
  rwc_link_src src (.core_clk(core_clk), .link_bclk(link_bclk),
    .link_data(link_data), .link_frame(link_frame));
  rwc_display #(.CHANNELS(4), .HALF_SEC_CYC(HALF)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .link_bclk(link_bclk),
    .link_data(link_data), .link_frame(link_frame),
    .word_data(word_data), .word_vld(word_vld), .word_err(word_err),
    .chan_page(chan_page), .chan_bottom(chan_bottom),
    .scan_vld(scan_vld), .scan_char(scan_char), .scan_page(scan_page),
    .scan_line(scan_line), .scan_col(scan_col), .scan_frame(scan_frame),
    .chan_hit(chan_hit), .upd_tick(upd_tick), .upd_stale(upd_stale));
  // ==========================================================
  // checking and closing
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string msg);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wait_ans(output logic v, output logic e);
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge core_clk);
      #2;
      if (word_vld === 1'b1 || word_err === 1'b1) break;
    end
    if (n == 600) begin
      check(1'b0, 1'b1, "no answer");
      report_and_stop();
    end
    v = word_vld;
    e = word_err;
  endtask : wait_ans
  task automatic wait_scan(input logic [15:0] pos);
    int n;
    for (n = 0; n < 25000; n++) begin
      @(posedge core_clk);
      #2;
      if ({scan_page, scan_line, scan_col} === pos) break;
    end
    if (n == 25000) begin
      check(1'b0, 1'b1, "scan timeout");
      report_and_stop();
    end
  endtask : wait_scan
  // cycles between two pulses of tick (sel) or frame marker
  task automatic gap(input logic sel, output int cyc);
    int n;
    cyc = 0;
    for (n = 0; n < 50000; n++) begin
      @(posedge core_clk);
      #2;
      if ((sel ? upd_tick : scan_frame) === 1'b1) begin
        if (cyc > 0) break;
        cyc = 1;
      end else if (cyc > 0) begin
        cyc++;
      end
    end
    if (n == 50000) begin
      check(1'b0, 1'b1, "pulse timeout");
      report_and_stop();
    end
  endtask : gap
  // ==========================================================
  // main sequence
  initial begin
    int r, cyc;
    logic v, e;
    rwc_word_t last;
    logic [5:0] blink_exp;
    last = 12'h000;
    @(posedge core_clk);
    #2;
    check({word_vld, word_err, scan_vld, upd_stale}, 4'h0, "reset flags");
    check(word_data, 12'h000, "reset word");
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    for (r = 0; r < 11; r++) begin
      fork
        src.send_pair(rows[r].w, rows[r].bad);
        wait_ans(v, e);
      join
      check(v, rows[r].vld, "accept flag");
      check(e, rows[r].err, "mismatch flag");
      if (!rows[r].bad) last = rows[r].w;
      check(word_data, last, "parallel word");
    end
    gap(1'b1, cyc);
    check(cyc, 2 * HALF, "update tick period");
    check(upd_stale, 1'b1, "no write in last second");
    gap(1'b0, cyc);
    check(cyc, 20480, "scan period");
    check({scan_page, scan_line, scan_col}, 16'h9E5F, "last place");
    wait_scan(16'h0005);
    check(scan_vld, 1'b1, "scan valid");
    check(scan_char, 6'h2A, "written char");
    check(chan_hit, 4'h1, "top half hit");
    wait_scan(16'h0006);
    // blink phase starts low at release and toggles every HALF cycles
    blink_exp = ((run_cyc - 1) / HALF) % 2 ? 6'h00 : 6'h15;
    check(scan_char, blink_exp, "blink");
    wait_scan(16'h9A00);
    check(chan_hit, 4'h0, "top half of bottom page");
    wait_scan(16'h9B40);
    check(chan_hit, 4'h8, "bottom half hit");
    check(scan_char, 6'h01, "body char on page 19");
    // reset in mid-run
    @(posedge core_clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #2;
    check({word_vld, word_err, scan_vld, scan_frame, upd_tick, upd_stale,
      chan_hit}, 10'h000, "mid-run reset flags");
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    @(posedge core_clk);
    #2;
    check({scan_vld, scan_page, scan_line, scan_col}, 17'h10000, "restart");
    @(posedge core_clk);
    #2;
    check(scan_col, 6'h01, "scan advances");
    report_and_stop();
  end
endmodule : tb_redundant_word_char_display
